// >>> bench/ccs_bus_model.sv
// Far-side bus model giving bit samples and bus level to the controller.
`timescale 1ns/10ps
module ccs_bus_model
    import ccs_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Level request from the bench
    input  wire logic dominant,
    // Bit stream
    output logic      bit_tick,
    output logic      rx_bit
);
    logic [1:0] div_q;

    // ********
    // Bit timing
    // ********
    // One bit sample every fourth clock keeps recovery runs short.
    always_ff @(posedge core_clk)
    begin
        if (reset)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end

    // Off the sample the level toggles, so a stale value never looks valid.
    assign bit_tick = (div_q == 2'h3);
    assign rx_bit   = bit_tick ? ~dominant : div_q[0];
endmodule

// >>> bench/testbench.sv
// Self-checking testbench for the CAN control/status register block.
`timescale 1ns/10ps
module testbench
    import ccs_pkg::*;
;
    logic        core_clk, reset, bus_rd, bus_wr, bus_off, error_warning;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, rdat;
    logic [1:0]  bus_be;
    ccs_evt_t    eng_evt;
    logic        bit_tick, rx_bit, dominant, xfer_allow, bt_write_en;
    logic        test_mode, irq;
    int          fail_count, num_checks;

    // ********
    // Design, bus model and clock
    // ********
    ccs_ctrl i_dut (.core_clk(core_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .eng_evt(eng_evt), .bus_off(bus_off),
        .error_warning(error_warning), .bit_tick(bit_tick),
        .rx_bit(rx_bit), .xfer_allow(xfer_allow),
        .bt_write_en(bt_write_en), .test_mode(test_mode), .irq(irq));
    ccs_bus_model i_bus (.core_clk(core_clk), .reset(reset),
        .dominant(dominant), .bit_tick(bit_tick), .rx_bit(rx_bit));

    // The clock toggles every half period of 5 ns.
    always #5 core_clk = ~core_clk;

    // ********
    // Tasks
    // ********
    // Waits whole cycles, then steps just past the edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One register write, held for one sampling edge.
    task automatic wr(input logic [1:0] be, input logic [15:0] d);
        cyc(1);
        bus_addr = CCS_CSR_ADDR;
        bus_be = be;
        bus_wdata = d;
        bus_wr = 1'b1;
        cyc(1);
        bus_wr = 1'b0;
    endtask

    // One register read; data is taken in the cycle after the edge.
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        cyc(1);
        bus_addr = a;
        bus_rd = 1'b1;
        cyc(1);
        bus_rd = 1'b0;
        d = bus_rdata;
    endtask

    // Compares a register word.
    task automatic chk16(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    // Compares a single output flag.
    task automatic chk1(input string n, input logic e, g);
        num_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %b seen %b", n, e, g);
            fail_count++;
        end
    endtask

    // Reads the register and compares it.
    task automatic rchk(input logic [15:0] e);
        logic [15:0] d;
        rd(CCS_CSR_ADDR, d);
        chk16("csr", e, d);
    endtask

    // Sends one engine event pulse, then lets the flags settle.
    task automatic ev(input logic t, r, v, input logic [2:0] c);
        cyc(1);
        eng_evt = {t, r, v, c};
        cyc(1);
        eng_evt = '0;
        cyc(1);
    endtask

    // Waits until n bit samples were taken by the design.
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge core_clk);
            while (bit_tick !== 1'b1)
                @(negedge core_clk);
            @(posedge core_clk);
        end
        #1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end

    // ********
    // Test sequence
    // ********
    // Bus level and recovery scenarios in order; software keeps bit 7 zero.
    initial
    begin
        {core_clk, bus_rd, bus_wr, bus_off, error_warning, dominant} = '0;
        {bus_addr, bus_wdata, bus_be, eng_evt} = '0;
        fail_count = 0;
        num_checks = 0;
        reset = 1'b1;
        cyc(16);
        reset = 1'b0;
        rchk(16'h0001);
        chk1("irq", 1'b0, irq);
        rd(16'hEF10, rdat);
        chk16("unmapped", 16'h0000, rdat);
        wr(2'h1, 16'h007F);
        cyc(20);
        chk1("xfer", 1'b0, xfer_allow);
        chk1("btw", 1'b1, bt_write_en);
        dominant = 1'b1;
        wr(2'h3, 16'hE07E);
        ticks(3);
        dominant = 1'b0;
        ticks(10);
        chk1("xfer", 1'b0, xfer_allow);
        ticks(1);
        cyc(2);
        chk1("xfer", 1'b1, xfer_allow);
        rchk(16'h004E);
        ev(1'b1, 1'b0, 1'b0, 3'h0);
        chk1("irq", 1'b1, irq);
        rchk(16'h084E);
        chk1("irq", 1'b0, irq);
        rchk(16'h084E);
        for (int c = 1; c < 7; c++)
        begin
            ev(1'b0, 1'b0, 1'b1, 3'(c));
            chk1("irq", 1'b1, irq);
            rchk(16'h084E | {5'h00, 3'(c), 8'h00});
        end
        ev(1'b0, 1'b0, 1'b1, CCS_LEC_UNUSED);
        rchk(16'h0E4E);
        ev(1'b0, 1'b1, 1'b0, 3'h0);
        rchk(16'h184E);
        wr(2'h2, 16'h0000);
        rchk(16'h004E);
        wr(2'h1, 16'h004C);
        ev(1'b1, 1'b0, 1'b0, 3'h0);
        chk1("irq", 1'b0, irq);
        rchk(16'h084C);
        wr(2'h3, 16'h004E);
        error_warning = 1'b1;
        cyc(2);
        chk1("irq", 1'b1, irq);
        rchk(16'h404E);
        bus_off = 1'b1;
        cyc(2);
        chk1("irq", 1'b1, irq);
        chk1("xfer", 1'b0, xfer_allow);
        rchk(16'hC04F);
        wr(2'h1, 16'h004E);
        dominant = 1'b1;
        ticks(1);
        dominant = 1'b0;
        ticks(11);
        cyc(2);
        rchk(16'hC54E);
        chk1("xfer", 1'b0, xfer_allow);
        {bus_off, error_warning, dominant} = 3'h1;
        ticks(1);
        dominant = 1'b0;
        chk1("xfer", 1'b0, xfer_allow);
        ticks(11);
        cyc(2);
        chk1("xfer", 1'b1, xfer_allow);
        rchk(16'h054E);
        wr(2'h1, 16'h004F);
        rchk(16'h054F);
        chk1("btw", 1'b1, bt_write_en);
        chk1("xfer", 1'b0, xfer_allow);
        chk1("test", 1'b0, test_mode);
        wr(2'h1, 16'h0007);
        chk1("btw", 1'b0, bt_write_en);
        rchk(16'h0507);
        error_warning = 1'b1;
        cyc(2);
        chk1("irq", 1'b0, irq);
        rchk(16'h4507);
        wrap_up();
    end
endmodule

// >>> hw/ccs_ctrl.sv
// CAN control/status register with init hold, recovery and interrupts.
// Function
// - While the init hold bit is set no new transfer may start.
// - Setting init hold keeps configuration and lets a running frame end.
// - Entering bus-off sets the init hold bit in hardware.
// - After init hold clears, 11 recessive bits are seen before activity.
// - The global enable gates every interrupt but never status updates.
// - Status-change enable asks an interrupt on success or a recorded error.
// - Error enable asks an interrupt on any change of bus-off or warning.
// - Field layout is fixed; bits 13, 5 and 4 read as zero.
// - After reset the low byte reads 01h.
// - Error codes 0 to 6 are recorded; success clears; 7 never by hardware.
// - The configuration change bit grants bit timing write access.
// - The transmit success flag is cleared only by a CPU write.
`timescale 1ns/10ps
module ccs_ctrl
    import ccs_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Peripheral bus, 16-bit word with byte enables
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [1:0]  bus_be,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata,
    // Protocol engine status
    input  wire ccs_evt_t    eng_evt,
    input  wire logic        bus_off,
    input  wire logic        error_warning,
    input  wire logic        bit_tick,
    input  wire logic        rx_bit,
    // Controls to the protocol engine
    output logic             xfer_allow,
    output logic             bt_write_en,
    output logic             test_mode,
    // Interrupt request
    output logic             irq
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic        hit, wr_lo, wr_hi, rd_hit;
    logic [15:0] csr_word;

    // Word decode; byte enables pick the lanes that a write touches.
    assign hit    = (bus_addr[15:1] == CCS_CSR_ADDR[15:1]);
    assign wr_lo  = bus_wr && hit && bus_be[0];
    assign wr_hi  = bus_wr && hit && bus_be[1];
    assign rd_hit = bus_rd && hit;

    // ************************************************************
    // Control byte
    // ************************************************************
    logic init_q, gie_q, sie_q, eie_q, cce_q, tst_q;
    logic bus_off_flag_q, error_warning_flag_q, bus_off_flag_rise;

    // Bus-off entry is a rise against the sample of the last cycle.
    assign bus_off_flag_rise = bus_off && !bus_off_flag_q;
    // Init hold: bus-off entry sets it and wins over a CPU clear.
    always_ff @(posedge core_clk)
    begin
        if (reset)
            init_q <= CCS_CSR_RESET[CCS_B_INIT];
        else if (bus_off_flag_rise)
            init_q <= 1'b1;
        else if (wr_lo)
            init_q <= bus_wdata[CCS_B_INIT];
    end

    // Enables, configuration change and test bits of the low byte.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            gie_q <= CCS_CSR_RESET[CCS_B_GIE];
            sie_q <= CCS_CSR_RESET[CCS_B_SIE];
            eie_q <= CCS_CSR_RESET[CCS_B_EIE];
            cce_q <= CCS_CSR_RESET[CCS_B_CCE];
            tst_q <= CCS_CSR_RESET[CCS_B_TST];
        end
        else if (wr_lo)
        begin
            gie_q <= bus_wdata[CCS_B_GIE];
            sie_q <= bus_wdata[CCS_B_SIE];
            eie_q <= bus_wdata[CCS_B_EIE];
            cce_q <= bus_wdata[CCS_B_CCE];
            tst_q <= bus_wdata[CCS_B_TST];
        end
    end

    // Bit timing access follows the configuration change bit.
    assign bt_write_en = cce_q;
    assign test_mode   = tst_q;

    // ************************************************************
    // Bus participation
    // ************************************************************
    ccs_state_t st_q;
    logic       idle_done;
    ccs_idle_detect u_idle (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (st_q == CCS_ST_WAIT),
        .bit_tick (bit_tick),
        .rx_bit   (rx_bit),
        .seq_done (idle_done)
    );

    // Hold, wait for a quiet bus, then run; bus-off keeps it waiting.
    always_ff @(posedge core_clk)
    begin
        if (reset)
            st_q <= CCS_ST_INIT;
        else
        begin
            case (st_q)
                CCS_ST_INIT:
                    if (!init_q)
                        st_q <= CCS_ST_WAIT;
                CCS_ST_WAIT:
                    if (init_q)
                        st_q <= CCS_ST_INIT;
                    else if (idle_done && !bus_off)
                        st_q <= CCS_ST_RUN;
                CCS_ST_RUN:
                    if (init_q || bus_off_flag_rise)
                        st_q <= CCS_ST_INIT;
                default:
                    st_q <= CCS_ST_INIT;
            endcase
        end
    end

    // Only new starts are gated; a frame under way runs to its end.
    assign xfer_allow = (st_q == CCS_ST_RUN) && !init_q;

    // ************************************************************
    // Status byte
    // ************************************************************
    logic       tx_success_flag_q, rx_success_flag_q;
    logic [2:0] lec_q;

    // Success flags: hardware sets, only a CPU write clears.
    always_ff @(posedge core_clk)
    begin
        if (reset)
            tx_success_flag_q <= 1'b0;
        else if (eng_evt.tx_ok)
            tx_success_flag_q <= 1'b1;
        else if (wr_hi)
            tx_success_flag_q <= bus_wdata[CCS_B_TX_SUCCESS_FLAG];
        if (reset)
            rx_success_flag_q <= 1'b0;
        else if (eng_evt.rx_ok)
            rx_success_flag_q <= 1'b1;
        else if (wr_hi)
            rx_success_flag_q <= bus_wdata[CCS_B_RX_SUCCESS_FLAG];
    end

    // Last error code; recovery progress shows as the bit-zero code.
    always_ff @(posedge core_clk)
    begin
        if (reset)
            lec_q <= CCS_LEC_NONE;
        else if (eng_evt.err_valid && eng_evt.err_code != CCS_LEC_UNUSED)
            lec_q <= eng_evt.err_code;
        else if (idle_done && bus_off)
            lec_q <= CCS_LEC_BIT0;
        else if (eng_evt.tx_ok || eng_evt.rx_ok)
            lec_q <= CCS_LEC_NONE;
        else if (wr_hi)
            lec_q <= bus_wdata[CCS_B_LEC_HI:CCS_B_LEC_LO];
    end

    // Samples of the error state, used to see its changes; reset clears.
    always_ff @(posedge core_clk)
    begin
        bus_off_flag_q <= bus_off && !reset;
        error_warning_flag_q <= error_warning && !reset;
    end

    // Register word as read by the CPU.
    always_comb
    begin
        csr_word                            = 16'h0000;
        csr_word[CCS_B_BUS_OFF_FLAG]                = bus_off_flag_q;
        csr_word[CCS_B_ERROR_WARNING_FLAG]                = error_warning_flag_q;
        csr_word[CCS_B_RX_SUCCESS_FLAG]                = rx_success_flag_q;
        csr_word[CCS_B_TX_SUCCESS_FLAG]                = tx_success_flag_q;
        csr_word[CCS_B_LEC_HI:CCS_B_LEC_LO] = lec_q;
        csr_word[CCS_B_TST]                 = tst_q;
        csr_word[CCS_B_CCE]                 = cce_q;
        csr_word[CCS_B_EIE]                 = eie_q;
        csr_word[CCS_B_SIE]                 = sie_q;
        csr_word[CCS_B_GIE]                 = gie_q;
        csr_word[CCS_B_INIT]                = init_q;
    end

    // Read data register; unmapped reads return zero.
    always_ff @(posedge core_clk)
    begin
        if (rd_hit && !reset)
            bus_rdata <= csr_word;
        else
            bus_rdata <= 16'h0000;
    end

    // ************************************************************
    // Interrupt request
    // ************************************************************
    logic stat_pend_q, err_pend_q, stat_evt, err_evt;

    // Events that set the two pending bits.
    assign stat_evt = eng_evt.tx_ok || eng_evt.rx_ok ||
                      (eng_evt.err_valid &&
                       eng_evt.err_code != CCS_LEC_UNUSED);
    assign err_evt  = (bus_off != bus_off_flag_q) || (error_warning != error_warning_flag_q);

    // Pending events are sticky; a register read clears, a new event wins.
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stat_pend_q <= 1'b0;
            err_pend_q  <= 1'b0;
        end
        else
        begin
            if (stat_evt)
                stat_pend_q <= 1'b1;
            else if (rd_hit)
                stat_pend_q <= 1'b0;
            if (err_evt)
                err_pend_q <= 1'b1;
            else if (rd_hit)
                err_pend_q <= 1'b0;
        end
    end

    // Global enable gates only the request, never the flags above.
    assign irq = gie_q && ((sie_q && stat_pend_q) ||
                           (eie_q && err_pend_q));

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Waiting with init clear, a quiet bus just seen and no CPU write.
    sequence s_quiet_seen;
        st_q == CCS_ST_WAIT && !init_q && idle_done && !bus_off && !wr_lo;
    endsequence
    a_init_blocks_start: assert property (init_q |-> !xfer_allow)
        else $error("transfer allowed while init hold is set");
    a_busoff_sets_init: assert property (bus_off_flag_rise |=> init_q)
        else $error("bus-off entry did not set init hold");
    a_run_after_idle: assert property
        ($rose(xfer_allow) |-> $past(idle_done) && !$past(bus_off))
        else $error("bus activity started without 11 recessive bits");
    a_cleared_waits: assert property
        ((st_q == CCS_ST_WAIT && !(idle_done && !bus_off)) |=> !xfer_allow)
        else $error("left wait state without quiet bus");
    a_quiet_runs: assert property (s_quiet_seen |=> xfer_allow)
        else $error("no bus activity after 11 recessive bits");
    a_gie_blocks_irq: assert property (!gie_q |-> !irq)
        else $error("interrupt raised with global enable clear");
    a_status_irq: assert property
        ((gie_q && sie_q && eng_evt.tx_ok && !wr_lo) |=> irq)
        else $error("no interrupt after successful transmission");
    a_err_irq: assert property
        ((gie_q && eie_q && bus_off != bus_off_flag_q && !wr_lo)
         |=> irq ##1 (irq || $past(rd_hit) || $past(wr_lo)))
        else $error("no interrupt after error state change");
    a_reserved_zero: assert property
        (bus_rdata[13] == 1'b0 && bus_rdata[5:4] == 2'h0)
        else $error("reserved bit read as one");
    a_reset_low_byte: assert property
        ($past(reset) |-> csr_word[7:0] == 8'h01)
        else $error("low byte after reset is not 01h");
    a_success_clears: assert property
        ((eng_evt.rx_ok && !eng_evt.err_valid && !idle_done)
         |=> lec_q == CCS_LEC_NONE)
        else $error("error code not cleared after good transfer");
    a_tx_success_flag_sticky: assert property (tx_success_flag_q && !wr_hi |=> tx_success_flag_q)
        else $error("transmit success cleared without CPU write");
    a_cce_grants: assert property
        (wr_lo |=> bt_write_en == $past(bus_wdata[CCS_B_CCE]))
        else $error("bit timing access differs from enable bit");
endmodule

// >>> hw/ccs_idle_detect.sv
// Counter that finds runs of consecutive recessive bits on the bus.
`timescale 1ns/10ps
module ccs_idle_detect
    import ccs_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Bit stream from the protocol engine
    input  wire logic run,
    input  wire logic bit_tick,
    input  wire logic rx_bit,
    // Result
    output logic      seq_done
);

    logic [3:0] cnt_q;
    logic       done_q;

    // Counts recessive bits, restarts on dominant or when stopped.
    always_ff @(posedge core_clk)
    begin
        if (reset || !run)
        begin
            cnt_q  <= 4'h0;
            done_q <= 1'b0;
        end
        else if (bit_tick && !rx_bit)
        begin
            cnt_q  <= 4'h0;
            done_q <= 1'b0;
        end
        else if (bit_tick && cnt_q == CCS_IDLE_BITS - 4'h1)
        begin
            cnt_q  <= 4'h0;
            done_q <= 1'b1;
        end
        else if (bit_tick)
        begin
            cnt_q  <= cnt_q + 4'h1;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
        end
    end

    assign seq_done = done_q;

endmodule

// >>> hw/ccs_pkg.sv
// Package with constants and types for the CAN control/status register.
package ccs_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [15:0] CCS_CSR_ADDR   = 16'hEF00;
    localparam logic [15:0] CCS_CSR_RESET  = 16'h0001;
    localparam int          CCS_B_INIT     = 0;
    localparam int          CCS_B_GIE      = 1;
    localparam int          CCS_B_SIE      = 2;
    localparam int          CCS_B_EIE      = 3;
    localparam int          CCS_B_CCE      = 6;
    localparam int          CCS_B_TST      = 7;
    localparam int          CCS_B_LEC_LO   = 8;
    localparam int          CCS_B_LEC_HI   = 10;
    localparam int          CCS_B_TX_SUCCESS_FLAG     = 11;
    localparam int          CCS_B_RX_SUCCESS_FLAG     = 12;
    localparam int          CCS_B_ERROR_WARNING_FLAG     = 14;
    localparam int          CCS_B_BUS_OFF_FLAG     = 15;

    // ************************************************************
    // Error codes and timing
    // ************************************************************
    localparam logic [2:0]  CCS_LEC_NONE   = 3'h0;
    localparam logic [2:0]  CCS_LEC_BIT0   = 3'h5;
    localparam logic [2:0]  CCS_LEC_UNUSED = 3'h7;
    localparam logic [3:0]  CCS_IDLE_BITS  = 4'hB;

    // Events reported by the protocol engine, one-cycle pulses.
    typedef struct packed {
        logic       tx_ok;
        logic       rx_ok;
        logic       err_valid;
        logic [2:0] err_code;
    } ccs_evt_t;

    // Bus participation state.
    typedef enum logic [2:0] {
        CCS_ST_INIT = 3'h1,
        CCS_ST_WAIT = 3'h2,
        CCS_ST_RUN  = 3'h4
    } ccs_state_t;

endpackage
